// >>> core/dual_clock_fifo_flag_modes.v
// Dual-clock 18-bit FIFO with reset-sampled mode code, flags and APB control
//
// Operation
// R1: reset code selects single-device configuration
// R2: depth is one FIFO's worth of words
// R3: codes 100/101/110 give read-clocked almost-empty
// R4: almost-full updated only on write clock
// R5: almost-empty release may slip one read cycle
// R6: almost-full release may slip one write cycle
// R7: double-buffered full release one extra cycle
// R8: double-buffered empty release one extra cycle
// R9: fall-through output-valid flag tracks output stage
// R10: fall-through depth is one word larger
// R11: pulse on read from last location
// R12: almost-empty at n, or n+1 fall-through
// R13: almost-full after depth minus m writes
// R14: mode pins held static through operation
// R15: pointers cross domains as two-flop Gray code
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fifo_flags_map.vh"

module dual_clock_fifo_flag_modes #(
    parameter ADDR_W = 8,
    parameter DATA_W = 18
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire first_load,
    input wire read_chain_in,
    input wire write_chain_in,
    input wire write_enable,
    input wire [DATA_W-1:0] write_data,
    output reg full_n,
    output reg in_room_n,
    output reg almost_full_n,
    input wire read_clock,
    input wire read_enable,
    output reg [DATA_W-1:0] read_data,
    output reg empty_n,
    output reg out_valid_n,
    output reg almost_empty_n,
    output reg read_chain_out
);

localparam PTR_W = ADDR_W + 2;
localparam DEPTH = 1 << ADDR_W;
localparam [PTR_W-1:0] DEPTH_P = {2'b01, {ADDR_W{1'b0}}};
localparam [PTR_W-1:0] ONE_P = {{(PTR_W-1){1'b0}}, 1'b1};

function [PTR_W-1:0] bin2gray;
    input [PTR_W-1:0] b;
    begin
        bin2gray = b ^ (b >> 1);
    end
endfunction

function [PTR_W-1:0] gray2bin;
    input [PTR_W-1:0] g;
    integer i;
    begin
        gray2bin[PTR_W-1] = g[PTR_W-1];
        for (i = PTR_W - 2; i >= 0; i = i - 1) begin
            gray2bin[i] = gray2bin[i+1] ^ g[i];
        end
    end
endfunction

function is_fall_through_mode;
    input [2:0] c;
    begin
        is_fall_through_mode = (c == `CODE_FALL_THROUGH_MODE_A) || (c == `CODE_FALL_THROUGH_MODE_B);
    end
endfunction

function is_dbl;
    input [2:0] c;
    begin
        is_dbl = (c == `CODE_DBL_A) || (c == `CODE_DBL_B);
    end
endfunction

function is_sync;
    input [2:0] c;
    begin
        is_sync = (c == `CODE_SYNC_A) || (c == `CODE_SYNC_B) || (c == `CODE_SYNC_C);
    end
endfunction

reg [DATA_W-1:0] mem [0:DEPTH-1];

////////////////////////////////////////////////////////////////////////////////
// Write domain (pclk): mode capture, write pointer, full side flags

reg [2:0] wcfg_s1_ff, wcfg_s2_ff, wcfg_ff;
reg [1:0] wcfg_cnt_ff;
reg wcfg_done_ff;
reg [PTR_W-1:0] wr_bin_ff, wr_gray_ff, rgray_s1_ff, rgray_s2_ff;
reg [PTR_W-1:0] full_ofs_ff, empty_ofs_ff;
reg eofs_tog_ff, wrel_ff;
reg [PTR_W-1:0] rcons_gray_ff;

wire w_fall_through_mode = is_fall_through_mode(wcfg_ff);
wire w_dbl = is_dbl(wcfg_ff);
wire [PTR_W-1:0] rd_sync_bin = gray2bin(rgray_s2_ff);
wire [PTR_W-1:0] d_eff = DEPTH_P + {{(PTR_W-1){1'b0}}, w_fall_through_mode}; // R10
wire wr_take = write_enable & full_n & wcfg_done_ff;
wire [PTR_W-1:0] wr_nxt = wr_bin_ff + {{(PTR_W-1){1'b0}}, wr_take};
wire [PTR_W-1:0] wcnt_nxt = wr_nxt - rd_sync_bin;
wire nxt_full = (wcnt_nxt >= d_eff); // R2 R10
wire nxt_full_n = ~nxt_full & (~w_dbl | full_n | wrel_ff); // R7
wire nxt_almost_full_n = ~(wcnt_nxt >= (d_eff - full_ofs_ff)); // R13

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wcfg_s1_ff <= 3'h0;
        wcfg_s2_ff <= 3'h0;
        wcfg_ff <= 3'h0;
        wcfg_cnt_ff <= 2'h0;
        wcfg_done_ff <= 1'b0;
    end else begin
        wcfg_s1_ff <= {first_load, read_chain_in, write_chain_in};
        wcfg_s2_ff <= wcfg_s1_ff;
        if (!wcfg_done_ff) begin
            wcfg_cnt_ff <= wcfg_cnt_ff + 2'h1;
            if (wcfg_cnt_ff == `CFG_SETTLE) begin
                wcfg_ff <= wcfg_s2_ff; // R1 R14
                wcfg_done_ff <= 1'b1;
            end
        end
    end
end

always @(posedge pclk) begin
    if (wr_take) begin
        mem[wr_bin_ff[ADDR_W-1:0]] <= write_data;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wr_bin_ff <= {PTR_W{1'b0}};
        wr_gray_ff <= {PTR_W{1'b0}};
        rgray_s1_ff <= {PTR_W{1'b0}};
        rgray_s2_ff <= {PTR_W{1'b0}};
        full_n <= 1'b1;
        in_room_n <= 1'b0;
        almost_full_n <= 1'b1;
        wrel_ff <= 1'b1;
    end else begin
        wr_bin_ff <= wr_nxt;
        wr_gray_ff <= bin2gray(wr_nxt); // R15
        rgray_s1_ff <= rcons_gray_ff; // R15
        rgray_s2_ff <= rgray_s1_ff;
        wrel_ff <= ~nxt_full;
        full_n <= nxt_full_n;
        in_room_n <= ~nxt_full_n;
        almost_full_n <= nxt_almost_full_n; // R4 R6
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read domain: mode capture, fetch pointer, output stage, empty side flags

reg [2:0] rcfg_s1_ff, rcfg_s2_ff, rcfg_ff;
reg [1:0] rcfg_cnt_ff;
reg rcfg_done_ff;
reg [PTR_W-1:0] rd_ptr_ff, wgray_s1_ff, wgray_s2_ff, eofs_r_ff;
reg stage_ff, rrel_ff, uf_tog_ff, rco_tog_ff;
reg etog_s1_ff, etog_s2_ff, etog_s3_ff;

wire r_fall_through_mode = is_fall_through_mode(rcfg_ff);
wire r_dbl = is_dbl(rcfg_ff);
wire [PTR_W-1:0] wr_sync_bin = gray2bin(wgray_s2_ff);
wire ram_avail = (wr_sync_bin != rd_ptr_ff);
wire rd_ready = r_fall_through_mode ? stage_ff : empty_n;
wire fetch = rcfg_done_ff & (r_fall_through_mode ? (ram_avail & (~stage_ff | read_enable))
                                    : (read_enable & empty_n));
wire [PTR_W-1:0] rd_nxt = rd_ptr_ff + {{(PTR_W-1){1'b0}}, fetch};
wire stage_nxt = r_fall_through_mode & (fetch | (stage_ff & ~read_enable));
wire [PTR_W-1:0] cons_nxt = rd_nxt - {{(PTR_W-1){1'b0}}, stage_nxt};
wire [PTR_W-1:0] rcnt_nxt = wr_sync_bin - cons_nxt;
wire nxt_empty = (wr_sync_bin == rd_nxt);
wire nxt_empty_n = ~nxt_empty & (~r_dbl | empty_n | rrel_ff); // R8
wire [PTR_W-1:0] ae_lim = eofs_r_ff + (r_fall_through_mode ? ONE_P : {PTR_W{1'b0}});
wire last_loc = (rd_ptr_ff[ADDR_W-1:0] == {ADDR_W{1'b1}});

always @(posedge read_clock or negedge presetn) begin
    if (!presetn) begin
        rcfg_s1_ff <= 3'h0;
        rcfg_s2_ff <= 3'h0;
        rcfg_ff <= 3'h0;
        rcfg_cnt_ff <= 2'h0;
        rcfg_done_ff <= 1'b0;
    end else begin
        rcfg_s1_ff <= {first_load, read_chain_in, write_chain_in};
        rcfg_s2_ff <= rcfg_s1_ff;
        if (!rcfg_done_ff) begin
            rcfg_cnt_ff <= rcfg_cnt_ff + 2'h1;
            if (rcfg_cnt_ff == `CFG_SETTLE) begin
                rcfg_ff <= rcfg_s2_ff; // R1 R14
                rcfg_done_ff <= 1'b1;
            end
        end
    end
end

always @(posedge read_clock) begin
    if (fetch) begin
        read_data <= mem[rd_ptr_ff[ADDR_W-1:0]];
    end
end

always @(posedge read_clock or negedge presetn) begin
    if (!presetn) begin
        rd_ptr_ff <= {PTR_W{1'b0}};
        rcons_gray_ff <= {PTR_W{1'b0}};
        wgray_s1_ff <= {PTR_W{1'b0}};
        wgray_s2_ff <= {PTR_W{1'b0}};
        eofs_r_ff <= {{(PTR_W-4){1'b0}}, `EMPTY_OFS_RESET};
        stage_ff <= 1'b0;
        rrel_ff <= 1'b0;
        empty_n <= 1'b0;
        out_valid_n <= 1'b1;
        almost_empty_n <= 1'b0;
        read_chain_out <= 1'b0;
        uf_tog_ff <= 1'b0;
        rco_tog_ff <= 1'b0;
        etog_s1_ff <= 1'b0;
        etog_s2_ff <= 1'b0;
        etog_s3_ff <= 1'b0;
    end else begin
        wgray_s1_ff <= wr_gray_ff; // R15
        wgray_s2_ff <= wgray_s1_ff;
        etog_s1_ff <= eofs_tog_ff;
        etog_s2_ff <= etog_s1_ff;
        etog_s3_ff <= etog_s2_ff;
        if (etog_s2_ff != etog_s3_ff) begin
            eofs_r_ff <= empty_ofs_ff;
        end
        rd_ptr_ff <= rd_nxt;
        rcons_gray_ff <= bin2gray(cons_nxt); // R15 R10
        stage_ff <= stage_nxt;
        out_valid_n <= ~stage_nxt; // R9
        rrel_ff <= ~nxt_empty;
        empty_n <= nxt_empty_n;
        almost_empty_n <= ~(rcnt_nxt <= ae_lim); // R3 R5 R12
        read_chain_out <= fetch & last_loc; // R11
        if (fetch & last_loc) begin
            rco_tog_ff <= ~rco_tog_ff;
        end
        if (rcfg_done_ff & read_enable & ~rd_ready) begin
            uf_tog_ff <= ~uf_tog_ff;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave and interrupt logic (pclk)

reg [`IRQ_W-1:0] irq_status_ff, irq_enable_ff;
reg [2:0] uf_sync_ff, rco_sync_ff;
reg [31:0] nxt_prdata;
reg nxt_pslverr;

wire acc = psel & penable & ~pready;
wire done_wr = psel & penable & pready & pwrite & ~pslverr;
wire [`IRQ_W-1:0] clr_mask = (done_wr && paddr == `IRQ_CLEAR_ADDR) ?
                             pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
wire [`IRQ_W-1:0] evt;
wire [`IRQ_W-1:0] nxt_status;

assign evt[`IRQ_OVERFLOW] = write_enable & ~full_n & wcfg_done_ff;
assign evt[`IRQ_ALMOST_FULL] = almost_full_n & ~nxt_almost_full_n;
assign evt[`IRQ_UNDERFLOW] = uf_sync_ff[1] ^ uf_sync_ff[2];
assign evt[`IRQ_CHAIN_OUT] = rco_sync_ff[1] ^ rco_sync_ff[2];
assign nxt_status = (irq_status_ff & ~clr_mask) | evt;

always @* begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    case (paddr)
        `EMPTY_OFS_ADDR: nxt_prdata[PTR_W-1:0] = empty_ofs_ff;
        `FULL_OFS_ADDR: nxt_prdata[PTR_W-1:0] = full_ofs_ff;
        `CONFIG_ADDR: nxt_prdata[6:0] = {wcfg_done_ff, is_sync(wcfg_ff), w_dbl,
                                          w_fall_through_mode, wcfg_ff};
        `FLAGS_ADDR: begin
            nxt_prdata[PTR_W-1:0] = wr_bin_ff - rd_sync_bin;
            nxt_prdata[17:16] = {almost_full_n, full_n};
        end
        `IRQ_STATUS_ADDR: nxt_prdata[`IRQ_W-1:0] = irq_status_ff;
        `IRQ_CLEAR_ADDR: nxt_prdata = 32'h00000000;
        `IRQ_ENABLE_ADDR: nxt_prdata[`IRQ_W-1:0] = irq_enable_ff;
        default: nxt_pslverr = 1'b1;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        irq <= 1'b0;
        irq_status_ff <= {`IRQ_W{1'b0}};
        irq_enable_ff <= {`IRQ_W{1'b0}};
        empty_ofs_ff <= {{(PTR_W-4){1'b0}}, `EMPTY_OFS_RESET};
        full_ofs_ff <= {{(PTR_W-4){1'b0}}, `FULL_OFS_RESET};
        eofs_tog_ff <= 1'b0;
        uf_sync_ff <= 3'h0;
        rco_sync_ff <= 3'h0;
    end else begin
        pready <= acc;
        pslverr <= acc & nxt_pslverr;
        if (acc & ~pwrite) begin
            prdata <= nxt_prdata;
        end
        uf_sync_ff <= {uf_sync_ff[1:0], uf_tog_ff};
        rco_sync_ff <= {rco_sync_ff[1:0], rco_tog_ff};
        irq_status_ff <= nxt_status;
        irq <= |(nxt_status & irq_enable_ff);
        if (done_wr) begin
            case (paddr)
                `EMPTY_OFS_ADDR: begin
                    empty_ofs_ff <= pwdata[PTR_W-1:0];
                    eofs_tog_ff <= ~eofs_tog_ff;
                end
                `FULL_OFS_ADDR: full_ofs_ff <= pwdata[PTR_W-1:0];
                `IRQ_ENABLE_ADDR: irq_enable_ff <= pwdata[`IRQ_W-1:0];
                default: irq_enable_ff <= irq_enable_ff;
            endcase
        end
    end
end

endmodule

// >>> core/fifo_flags_map.vh
// Register offsets, field positions and reset values of the dual-clock FIFO
`ifndef FIFO_FLAGS_MAP_VH
`define FIFO_FLAGS_MAP_VH

`define EMPTY_OFS_ADDR 8'h00
`define FULL_OFS_ADDR 8'h04
`define CONFIG_ADDR 8'h08
`define FLAGS_ADDR 8'h0C
`define IRQ_STATUS_ADDR 8'h10
`define IRQ_CLEAR_ADDR 8'h14
`define IRQ_ENABLE_ADDR 8'h18

`define EMPTY_OFS_RESET 4'h7
`define FULL_OFS_RESET 4'h7

`define IRQ_OVERFLOW 0
`define IRQ_ALMOST_FULL 1
`define IRQ_UNDERFLOW 2
`define IRQ_CHAIN_OUT 3
`define IRQ_W 4

`define CODE_FALL_THROUGH_MODE_A 3'h1
`define CODE_FALL_THROUGH_MODE_B 3'h5
`define CODE_DBL_A 3'h2
`define CODE_DBL_B 3'h6
`define CODE_SYNC_A 3'h4
`define CODE_SYNC_B 3'h5
`define CODE_SYNC_C 3'h6

`define CFG_SETTLE 2'h2

`endif

// >>> verification/fifo_flags_properties.sv
// Port checks for the dual-clock FIFO flag block
`timescale 1ns/1ps
module fifo_flags_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic write_enable,
    input logic full_n,
    input logic in_room_n,
    input logic almost_full_n,
    input logic read_clock,
    input logic read_enable,
    input logic almost_empty_n,
    input logic read_chain_out
);
    chk_room_inverse:
    assert property (@(posedge pclk) disable iff (!presetn) in_room_n == !full_n)
        else $error("room flag mismatch");
    chk_apb_wait:
    assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("late ready");
    chk_ready_pulse:
    assert property (@(posedge pclk) disable iff (!presetn) pready |=> !pready)
        else $error("ready too long");
    chk_err_ready:
    assert property (@(posedge pclk) disable iff (!presetn) pslverr |-> pready)
        else $error("error without ready");
    chk_af_cause:
    assert property (@(posedge pclk) disable iff (!presetn)
        $fell(almost_full_n) |-> $past(write_enable)) else $error("af fell unprompted");
    chk_full_cause:
    assert property (@(posedge pclk) disable iff (!presetn)
        $fell(full_n) |-> $past(write_enable)) else $error("full unprompted");
    chk_ae_cause:
    assert property (@(posedge read_clock) disable iff (!presetn)
        $fell(almost_empty_n) |-> $past(read_enable)) else $error("ae fell unprompted");
    chk_chain_pulse:
    assert property (@(posedge read_clock) disable iff (!presetn)
        read_chain_out |=> !read_chain_out) else $error("chain pulse too long");
endmodule
bind dual_clock_fifo_flag_modes fifo_flags_checker chk_u (.*);

// >>> verification/fifo_read_agent.sv
// Read-side agent: read clock source and word collector
`timescale 1ns/1ps
module fifo_read_agent (
    output logic read_clock,
    output logic read_enable,
    input logic presetn,
    input logic rd_go,
    input logic fall_through_mode,
    input logic empty_n,
    input logic out_valid_n,
    input logic read_chain_out,
    input logic [17:0] read_data
);
    logic [17:0] got[$];
    logic take;
    int chains;
    initial begin
        read_clock = 0;
        read_enable = 0;
        chains = 0;
    end
    // Period unrelated to pclk so crossings see varying skew
    always #7 read_clock = ~read_clock;
    always @(posedge read_clock) begin
        take = read_enable && (fall_through_mode ? !out_valid_n : empty_n);
        chains += read_chain_out;
        read_enable <= rd_go && presetn;
        if (take && fall_through_mode) got.push_back(read_data);
        if (take && !fall_through_mode) #1 got.push_back(read_data);
    end
endmodule

// >>> verification/dual_clock_fifo_flag_modes_test.sv
// Self-checking bench for the dual-clock FIFO flags
`timescale 1ns/1ps
`include "fifo_flags_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module dual_clock_fifo_flag_modes_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic first_load = 0, read_chain_in = 0, write_chain_in = 0, fall_through_mode = 0;
    logic write_enable = 0, rd_go = 0, e;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    logic [17:0] write_data = 0;
    wire [31:0] prdata;
    wire [17:0] read_data;
    wire pready, pslverr, irq, full_n, in_room_n, almost_full_n, read_clock;
    wire read_enable, empty_n, out_valid_n, almost_empty_n, read_chain_out;
    int n_fail = 0, checks_done = 0, wr_n = 0;
    dual_clock_fifo_flag_modes dut_u (.*);
    fifo_read_agent rd_u (.*);
    always #5 pclk = ~pclk;
    ////////////////////////////////////////
    task tally_and_finish;
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rst(input logic [2:0] c);
        @(posedge pclk);
        presetn <= 0;
        {first_load, read_chain_in, write_chain_in} <= c;
        fall_through_mode <= c == 3'h1 || c == 3'h5;
        rd_go <= 0;
        repeat (3) @(posedge pclk);
        rd_u.got.delete();
        rd_u.chains = 0;
        wr_n = 0;
        presetn <= 1;
        repeat (8) @(posedge pclk);
    endtask
    task put(input int k);
        repeat (k) begin
            @(posedge pclk);
            write_enable <= 1;
            write_data <= wr_n[17:0];
            wr_n++;
        end
        @(posedge pclk);
        write_enable <= 0;
        repeat (10) @(posedge pclk);
    endtask
    task drain(input int k);
        rd_go <= 1;
        for (int i = 0; i < 3000 && rd_u.got.size() < k; i++) @(posedge pclk);
        rd_go <= 0;
        repeat (10) @(posedge pclk);
        `CHK(rd_u.got.size(), k)
        foreach (rd_u.got[i]) `CHK(rd_u.got[i], i[17:0])
    endtask
    logic [2:0] c_tab[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    task t_modes;
        logic [2:0] c;
        foreach (c_tab[i]) begin
            c = c_tab[i];
            rst(c);
            apb(0, `CONFIG_ADDR, 0);
            `CHK(q[6:0], {1'b1, c[2], c == 3'h2 || c == 3'h6, fall_through_mode, c})
        end
    endtask
    task t_regs;
        rst(3'h0);
        apb(0, `EMPTY_OFS_ADDR, 0);
        `CHK(q, 32'h7)
        apb(0, `FULL_OFS_ADDR, 0);
        `CHK(q, 32'h7)
        apb(0, 8'h1C, 0);
        `CHK(e, 1'b1)
        apb(0, `IRQ_CLEAR_ADDR, 0);
        `CHK(q, 32'h0)
    endtask
    task t_flow(input logic [2:0] c);
        logic f;
        f = (c == 3'h1 || c == 3'h5);
        rst(c);
        put(7 + f);
        `CHK(almost_empty_n, 1'b0)
        put(1);
        `CHK(almost_empty_n, 1'b1)
        `CHK(out_valid_n, !f)
        put(240);
        `CHK(almost_full_n, 1'b1)
        put(1);
        `CHK(almost_full_n, 1'b0)
        put(6);
        `CHK(full_n, 1'b1)
        put(1);
        `CHK(full_n, 1'b0)
        `CHK(in_room_n, 1'b1)
        drain(256 + f);
        `CHK(rd_u.chains, 1)
        `CHK(almost_empty_n, 1'b0)
        `CHK(full_n, 1'b1)
        `CHK(out_valid_n, 1'b1)
    endtask
    task t_irq;
        rst(3'h0);
        put(257);
        apb(0, `IRQ_STATUS_ADDR, 0);
        `CHK(q[0], 1'b1)
        apb(1, `IRQ_ENABLE_ADDR, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1, `IRQ_ENABLE_ADDR, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1, `IRQ_ENABLE_ADDR, 32'h1);
        apb(1, `IRQ_CLEAR_ADDR, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(0, `IRQ_STATUS_ADDR, 0);
        `CHK(q[0], 1'b0)
    endtask
    initial begin
        rst(3'h0);
        t_regs;
        t_modes;
        t_flow(3'h0);
        t_flow(3'h5);
        t_flow(3'h6);
        t_irq;
        tally_and_finish;
    end
    initial begin
        #300000;
        n_fail++;
        tally_and_finish;
    end
endmodule
